// [hdl/reset_pin_filter.sv]
`timescale 1ns/10ps
`default_nettype none
// Qualifies a low level on the reset pin for a least number of cycles
module reset_pin_filter #(
  parameter int CYCLES = sleep_ctl_pkg::RESET_MIN_CYC
) (
  input wire logic clk, // system clock
  input wire logic rst, // asynchronous reset
  input wire logic pin_low, // reset pin is low
  output logic hold // qualified reset request
);
  typedef struct packed {
    logic [15:0] cnt;
    logic hold;
  } state_t;
  state_t s, next_s;

  always_comb
  begin
    next_s = s;
    if (!pin_low)
    begin
      next_s.cnt = 16'h0;
      next_s.hold = 1'b0;
    end
    else if (s.cnt >= 16'(CYCLES - 1))
      next_s.hold = 1'b1;
    else
      next_s.cnt = s.cnt + 16'h1;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      s <= '0;
    else
      s <= next_s;
  end

  assign hold = s.hold;

  property p_filter_len;
    @(posedge clk) disable iff (rst)
    $rose(s.hold) |-> $past(pin_low, 1) && $past(pin_low, 2);
  endproperty
  a_filter_len: assert property (p_filter_len) else $error("reset held too short");
endmodule // reset_pin_filter
`default_nettype wire

// [hdl/sleep_ctl_pkg.sv]
`default_nettype none
package sleep_ctl_pkg;
  // Sleep mode field encoding; width of the software-held select
  localparam int MODE_W = 3;
  localparam logic [2:0] MODE_IDLE = 3'h0;
  localparam logic [2:0] MODE_ADC_NR = 3'h1;
  localparam logic [2:0] MODE_PWR_DOWN = 3'h2;
  localparam logic [2:0] MODE_PWR_SAVE = 3'h3;
  localparam logic [2:0] MODE_STANDBY = 3'h6;
  localparam logic [2:0] MODE_RESET = 3'h0;
  // Clock gate vector bit positions
  localparam int G_CPU = 0;
  localparam int G_IO = 1;
  localparam int G_ADC = 2;
  localparam int G_ASY = 3;
  localparam int G_OSC = 4;
  localparam int GATE_W = 5;
  localparam logic [4:0] GATES_ALL = 5'h1f;
  // Cycles spent restoring clocks before the core resumes
  localparam int WAKE_CYCLES = 4;
  // Minimum reset pulse length, in ns, and the derived filter count
  localparam int RESET_MIN_NS = 2500;
  localparam int CLK_NS = 8;
  localparam int RESET_MIN_CYC = (RESET_MIN_NS + CLK_NS - 1) / CLK_NS;
endpackage
`default_nettype wire

// [hdl/sleep_reset_ctl.sv]
`timescale 1ns/10ps
`default_nettype none
// How it works
// - Five software-selected sleep modes gate clocks
// - Idle stops CPU only, peripherals run
// - Power-down freezes oscillator until wake event
// - Power-save keeps asynchronous timer clock running
// - Noise reduction keeps async timer, converter, oscillator
// - Standby keeps oscillator running, rest asleep
// - Any reset tri-states all port pins; power-on reset does so clocklessly, pin reset needs clk to qualify
// - Fuse picks shared pin: port bit or reset
// - Reset needs low pulse beyond minimum width
// - RC clock plus select routes crystal pins
module sleep_reset_ctl #(
  parameter int PORT_W = 23,
  parameter int WAKE = sleep_ctl_pkg::WAKE_CYCLES
) (
  input wire logic clk, // system clock
  input wire logic rst, // power-on reset, async high
  input wire logic mode_wr, // write strobe for mode field
  input wire logic [2:0] mode_wdata, // mode value to write
  input wire logic sleep_enable, // sleep allowed by software
  input wire logic sleep_req, // core executes sleep, pulse
  input wire logic wake_event, // interrupt or wake source
  input wire logic reset_pin_disable_fuse, // fuse programmed, pin is I/O
  input wire logic shared_reset_port_pin_in, // level seen on shared pin
  input wire logic shared_port_out, // port logic drive for shared pin
  input wire logic shared_port_oe_n, // port logic enable, low drives
  input wire logic [PORT_W-1:0] port_out, // port logic drive values
  input wire logic [PORT_W-1:0] port_oe_n, // port enables, low drives
  input wire logic rc_clock_selected, // chip clocked from internal RC
  input wire logic async_timer_clock_select, // asynchronous clock select bit
  output logic [2:0] mode, // current mode field
  output logic sleeping, // device is asleep
  output logic cpu_run, // core clock enable
  output logic io_run, // peripheral clock enable
  output logic adc_run, // converter clock enable
  output logic async_run, // asynchronous timer enable
  output logic osc_run, // main oscillator enable
  output logic chip_reset, // combined reset to the chip
  output logic [PORT_W-1:0] pin_out, // port pin drive values
  output logic [PORT_W-1:0] pin_oe_n, // port pin enables, low drives
  output logic shared_pin_out, // shared pin drive value
  output logic shared_pin_oe_n, // shared pin enable, low drives
  output logic crystal_pins_to_timer // crystal pins serve timer oscillator
);
  typedef enum logic [1:0] {ACTIVE, ASLEEP, WAKING} phase_t;
  typedef struct packed {
    phase_t phase;
    logic [2:0] mode;
    logic [7:0] wcnt;
    logic [4:0] gates;
  } state_t;
  state_t s, next_s;
  logic pin_hold;
  logic ext_reset;

  function automatic logic [4:0] sleep_gates(input logic [2:0] m);
    logic [4:0] g;
    g = '0;
    case (m)
      sleep_ctl_pkg::MODE_IDLE:
      begin
        g[sleep_ctl_pkg::G_IO] = 1'b1;
        g[sleep_ctl_pkg::G_ADC] = 1'b1;
        g[sleep_ctl_pkg::G_ASY] = 1'b1;
        g[sleep_ctl_pkg::G_OSC] = 1'b1;
      end
      sleep_ctl_pkg::MODE_ADC_NR:
      begin
        g[sleep_ctl_pkg::G_ADC] = 1'b1;
        g[sleep_ctl_pkg::G_ASY] = 1'b1;
        g[sleep_ctl_pkg::G_OSC] = 1'b1;
      end
      sleep_ctl_pkg::MODE_PWR_SAVE: g[sleep_ctl_pkg::G_ASY] = 1'b1;
      sleep_ctl_pkg::MODE_STANDBY: g[sleep_ctl_pkg::G_OSC] = 1'b1;
      default: g = '0; // Power-down and unused codes freeze all
    endcase
    return g;
  endfunction

  reset_pin_filter u_filter (
    .clk(clk),
    .rst(rst),
    .pin_low(!reset_pin_disable_fuse && !shared_reset_port_pin_in),
    .hold(pin_hold)
  );

  // The pin reset is qualified on clk; a frozen clock still escapes via rst
  assign ext_reset = pin_hold;
  assign chip_reset = rst || ext_reset;

  always_comb
  begin
    next_s = s;
    if (mode_wr && s.phase == ACTIVE)
      next_s.mode = mode_wdata;
    case (s.phase)
      ACTIVE:
        if (sleep_req && sleep_enable)
        begin
          next_s.phase = ASLEEP;
          next_s.gates = sleep_gates(s.mode);
        end
      ASLEEP:
        if (wake_event)
        begin
          next_s.phase = WAKING;
          next_s.gates = sleep_ctl_pkg::GATES_ALL & ~5'h01;
          next_s.wcnt = 8'h0;
        end
      WAKING:
        if (s.wcnt >= 8'(WAKE - 1))
        begin
          next_s.phase = ACTIVE;
          next_s.gates = sleep_ctl_pkg::GATES_ALL;
        end
        else
          next_s.wcnt = s.wcnt + 8'h1;
      default: next_s.phase = ACTIVE;
    endcase
    if (ext_reset)
    begin
      next_s.phase = ACTIVE;
      next_s.gates = sleep_ctl_pkg::GATES_ALL;
      next_s.wcnt = 8'h0;
      next_s.mode = sleep_ctl_pkg::MODE_RESET;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s.phase <= ACTIVE;
      s.mode <= sleep_ctl_pkg::MODE_RESET;
      s.wcnt <= 8'h0;
      s.gates <= sleep_ctl_pkg::GATES_ALL;
    end
    else
      s <= next_s;
  end

  assign mode = s.mode;
  assign sleeping = (s.phase != ACTIVE);
  assign cpu_run = s.gates[sleep_ctl_pkg::G_CPU];
  assign io_run = s.gates[sleep_ctl_pkg::G_IO];
  assign adc_run = s.gates[sleep_ctl_pkg::G_ADC];
  assign async_run = s.gates[sleep_ctl_pkg::G_ASY];
  assign osc_run = s.gates[sleep_ctl_pkg::G_OSC];

  // Power-on reset path is purely combinational so pins float with no clock running; pin reset needs clk
  assign pin_out = port_out;
  assign pin_oe_n = chip_reset ? '1 : port_oe_n;
  assign shared_pin_out = shared_port_out;
  assign shared_pin_oe_n = (chip_reset || !reset_pin_disable_fuse) ? 1'b1
                           : shared_port_oe_n;
  assign crystal_pins_to_timer = rc_clock_selected && async_timer_clock_select;

  property p_tristate;
    @(posedge clk) chip_reset |-> (pin_oe_n == '1) && shared_pin_oe_n;
  endproperty
  a_tristate: assert property (p_tristate) else $error("pins driven in reset");

  property p_fuse_pin;
    @(posedge clk) disable iff (rst)
    !reset_pin_disable_fuse |-> shared_pin_oe_n;
  endproperty
  a_fuse_pin: assert property (p_fuse_pin) else $error("reset pin driven");

  property p_xtal;
    @(posedge clk) disable iff (rst)
    crystal_pins_to_timer == (rc_clock_selected && async_timer_clock_select);
  endproperty
  a_xtal: assert property (p_xtal) else $error("crystal pin routing wrong");

  property p_enter;
    @(posedge clk) disable iff (rst || ext_reset)
    (s.phase == ACTIVE && !(sleep_req && sleep_enable)) |=> !(s.phase == ASLEEP);
  endproperty
  a_enter: assert property (p_enter) else $error("sleep without request");

  property p_idle;
    @(posedge clk) disable iff (rst || ext_reset)
    (s.phase == ACTIVE && sleep_req && sleep_enable && s.mode == sleep_ctl_pkg::MODE_IDLE)
      |=> !cpu_run && io_run && async_run;
  endproperty
  a_idle: assert property (p_idle) else $error("idle gating wrong");

  property p_pdown;
    @(posedge clk) disable iff (rst || ext_reset)
    (sleeping && s.phase == ASLEEP && s.mode == sleep_ctl_pkg::MODE_PWR_DOWN) |-> !osc_run;
  endproperty
  a_pdown: assert property (p_pdown) else $error("oscillator runs in power-down");

  property p_psave;
    @(posedge clk) disable iff (rst || ext_reset)
    (s.phase == ASLEEP && s.mode == sleep_ctl_pkg::MODE_PWR_SAVE) |-> async_run && !io_run;
  endproperty
  a_psave: assert property (p_psave) else $error("power-save gating wrong");

  property p_adcnr;
    @(posedge clk) disable iff (rst || ext_reset)
    (s.phase == ASLEEP && s.mode == sleep_ctl_pkg::MODE_ADC_NR) |-> adc_run && !io_run;
  endproperty
  a_adcnr: assert property (p_adcnr) else $error("noise reduction gating wrong");

  property p_standby;
    @(posedge clk) disable iff (rst || ext_reset)
    (s.phase == ASLEEP && s.mode == sleep_ctl_pkg::MODE_STANDBY) |-> osc_run && !async_run;
  endproperty
  a_standby: assert property (p_standby) else $error("standby gating wrong");

  property p_wake;
    @(posedge clk) disable iff (rst || ext_reset)
    (s.phase == ASLEEP && wake_event) |=> !cpu_run && io_run && osc_run ##4 cpu_run;
  endproperty
  a_wake: assert property (p_wake) else $error("wake order wrong");

  property p_mode_hold;
    @(posedge clk) disable iff (rst || ext_reset)
    (s.phase == ACTIVE && mode_wr) |=> mode == $past(mode_wdata);
  endproperty
  a_mode_hold: assert property (p_mode_hold) else $error("mode not stored");

  property p_five;
    @(posedge clk) disable iff (rst)
    (s.phase == ASLEEP) |-> !cpu_run;
  endproperty
  a_five: assert property (p_five) else $error("core runs while asleep");
endmodule // sleep_reset_ctl
`default_nettype wire

// [sim/core_model.sv]
`timescale 1ns/10ps
`default_nettype none
// Core side: issues mode writes, sleep instructions and wake sources
module core_model (
  input wire logic clk, // system clock
  output logic mode_wr, // mode write strobe
  output logic [2:0] mode_wdata, // mode value
  output logic sleep_enable, // sleep allowed
  output logic sleep_req, // sleep instruction pulse
  output logic wake_event // wake source
);
  initial
  begin
    mode_wr = 1'b0;
    mode_wdata = 3'h0;
    sleep_enable = 1'b0;
    sleep_req = 1'b0;
    wake_event = 1'b0;
  end
  task automatic put_mode(input logic [2:0] m);
    @(posedge clk);
    mode_wr <= 1'b1;
    mode_wdata <= m;
    @(posedge clk);
    mode_wr <= 1'b0;
  endtask
  // Sleep only ever starts from this explicit one-cycle request
  task automatic sleep(input logic en);
    @(posedge clk);
    sleep_enable <= en;
    sleep_req <= 1'b1;
    @(posedge clk);
    sleep_req <= 1'b0;
  endtask
  task automatic wake();
    @(posedge clk);
    wake_event <= 1'b1;
    @(posedge clk);
    wake_event <= 1'b0;
  endtask
endmodule // core_model
`default_nettype wire

// [sim/tb_top.sv]
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) \
  begin checks++; if ((g) !== (e)) begin miscompares++; \
  $display("ERROR %s exp %0h got %0h", nm, e, g); end end
module tb_top;
  logic clk, rst, fuse, pin_in, sh_out, sh_oe_n, rc_sel, as_sel;
  logic [22:0] p_out, p_oe_n, pin_out, pin_oe_n;
  logic mode_wr, sleep_enable, sleep_req, wake_event, sleeping, chip_reset;
  logic cpu_run, io_run, adc_run, async_run, osc_run, shared_pin_out, shared_pin_oe_n, xtal;
  logic [2:0] mode_wdata, mode;
  logic [4:0] run;
  int miscompares = 0;
  int checks = 0;
  int cycles = 0;
  assign run = {osc_run, async_run, adc_run, io_run, cpu_run};
  core_model u_core_model (.clk, .mode_wr, .mode_wdata, .sleep_enable, .sleep_req,
    .wake_event);
  sleep_reset_ctl u_sleep_reset_ctl (.clk, .rst, .mode_wr, .mode_wdata, .sleep_enable,
    .sleep_req, .wake_event, .reset_pin_disable_fuse(fuse), .shared_reset_port_pin_in(pin_in),
    .shared_port_out(sh_out), .shared_port_oe_n(sh_oe_n), .port_out(p_out),
    .port_oe_n(p_oe_n), .rc_clock_selected(rc_sel), .async_timer_clock_select(as_sel),
    .mode, .sleeping, .cpu_run, .io_run, .adc_run, .async_run, .osc_run, .chip_reset,
    .pin_out, .pin_oe_n, .shared_pin_out, .shared_pin_oe_n, .crystal_pins_to_timer(xtal));
  always #4 clk = ~clk;
  // Ceiling well above the longest path, two long pin pulses included
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      miscompares++;
      summarize();
    end
  end
  task automatic summarize();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic t_modes();
    logic [2:0] cd [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6, 3'h7};
    logic [4:0] ex [6] = '{5'h1e, 5'h0c, 5'h00, 5'h08, 5'h10, 5'h00};
    logic [4:0] mk [6] = '{5'h1f, 5'h0f, 5'h1f, 5'h0f, 5'h1f, 5'h1f};
    for (int i = 0; i < 6; i++)
    begin
      u_core_model.put_mode(cd[i]);
      @(negedge clk);
      `CHK("mode", cd[i], mode)
      u_core_model.sleep(1'b1);
      repeat (2) @(posedge clk);
      @(negedge clk);
      `CHK("sleeping", 1'b1, sleeping)
      `CHK("gates", ex[i], run & mk[i])
      u_core_model.wake();
      repeat (2) @(posedge clk);
      @(negedge clk);
      `CHK("cpu held", 1'b0, cpu_run)
      `CHK("io back", 1'b1, io_run)
      // Core must stay held for exactly the wake count, then resume
      repeat (sleep_ctl_pkg::WAKE_CYCLES - 3) @(posedge clk);
      @(negedge clk);
      `CHK("cpu still held", 1'b0, cpu_run)
      @(posedge clk);
      @(negedge clk);
      `CHK("cpu back", 1'b1, cpu_run)
    end
    $display("test modes done");
  endtask
  task automatic t_refuse();
    u_core_model.sleep(1'b0);
    repeat (2) @(posedge clk);
    @(negedge clk);
    `CHK("no sleep", 1'b0, sleeping)
    u_core_model.put_mode(sleep_ctl_pkg::MODE_STANDBY);
    u_core_model.sleep(1'b1);
    u_core_model.put_mode(sleep_ctl_pkg::MODE_IDLE);
    @(negedge clk);
    `CHK("mode kept", sleep_ctl_pkg::MODE_STANDBY, mode)
    u_core_model.wake();
    repeat (8) @(posedge clk);
    $display("test refuse done");
  endtask
  task automatic t_pin();
    u_core_model.put_mode(sleep_ctl_pkg::MODE_PWR_SAVE);
    pin_in <= 1'b0;
    repeat (20) @(posedge clk);
    @(negedge clk);
    `CHK("short pulse", 1'b0, chip_reset)
    @(posedge clk);
    pin_in <= 1'b1;
    @(posedge clk);
    pin_in <= 1'b0;
    // One edge short of the minimum width must still be ignored
    repeat (sleep_ctl_pkg::RESET_MIN_CYC - 1) @(posedge clk);
    @(negedge clk);
    `CHK("pulse one short", 1'b0, chip_reset)
    @(posedge clk);
    @(negedge clk);
    `CHK("pin reset", 1'b1, chip_reset)
    `CHK("oe off", 23'h7fffff, pin_oe_n)
    `CHK("shared oe off", 1'b1, shared_pin_oe_n)
    @(posedge clk);
    @(negedge clk);
    `CHK("mode cleared", 3'h0, mode)
    @(posedge clk);
    pin_in <= 1'b1;
    repeat (3) @(posedge clk);
    @(negedge clk);
    `CHK("reset gone", 1'b0, chip_reset)
    `CHK("oe back", p_oe_n, pin_oe_n)
    `CHK("shared is reset in", 1'b1, shared_pin_oe_n)
    @(posedge clk);
    fuse <= 1'b1;
    pin_in <= 1'b0;
    repeat (400) @(posedge clk);
    @(negedge clk);
    `CHK("fuse io", 1'b0, chip_reset)
    `CHK("shared oe", sh_oe_n, shared_pin_oe_n)
    `CHK("shared out", sh_out, shared_pin_out)
    `CHK("port out", p_out, pin_out)
    $display("test pin done");
  endtask
  task automatic t_xtal();
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clk);
      rc_sel <= i[1];
      as_sel <= i[0];
      @(negedge clk);
      `CHK("xtal", logic'(i == 3), xtal)
    end
    $display("test xtal done");
  endtask
  initial
  begin
    clk = 1'b0;
    rst = 1'b1;
    fuse = 1'b0;
    pin_in = 1'b1;
    sh_out = 1'b1;
    sh_oe_n = 1'b0;
    p_out = 23'h2a5a5a;
    p_oe_n = 23'h0;
    rc_sel = 1'b0;
    as_sel = 1'b0;
    // Checked before the first edge: port release must not need a clock
    #1;
    `CHK("rst oe", 23'h7fffff, pin_oe_n)
    `CHK("rst shared oe", 1'b1, shared_pin_oe_n)
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    `CHK("rst mode", 3'h0, mode)
    `CHK("rst run", 5'h1f, run)
    t_modes();
    t_refuse();
    t_xtal();
    t_pin();
    summarize();
  end
endmodule // tb_top
`default_nettype wire
